// file: src/eqspi_cfg.svh
// Register offsets, field positions and reset values of the equalizer control bank.
// Assumes inclusion by its bare name from the design files.
`ifndef EQSPI_CFG_SVH
`define EQSPI_CFG_SVH
`define EQSPI_FRAME_BITS      16
`define EQSPI_ADDR_GENERAL    7'h00
`define EQSPI_ADDR_DRIVER     7'h01
`define EQSPI_ADDR_LAUNCH     7'h02
`define EQSPI_ADDR_CABLE      7'h06
`define EQSPI_ADDR_DUMMY      7'h7f
`define EQSPI_GEN_CARRIER     7
`define EQSPI_GEN_MUTE        6
`define EQSPI_GEN_BYPASS      5
`define EQSPI_GEN_SLEEP_HI    4
`define EQSPI_GEN_SLEEP_LO    3
`define EQSPI_DRV_SWING_HI    7
`define EQSPI_DRV_SWING_LO    6
`define EQSPI_DRV_VCM_HI      5
`define EQSPI_DRV_VCM_LO      4
`define EQSPI_DRV_DEEMPH_EN   3
`define EQSPI_DRV_DEEMPH_HI   2
`define EQSPI_DRV_DEEMPH_LO   1
`define EQSPI_LAU_ATTEN       7
`define EQSPI_RST_GENERAL     8'h08
`define EQSPI_RST_DRIVER      8'ha2
`define EQSPI_RST_LAUNCH      8'h68
`define EQSPI_GEN_WMASK       8'h7b
`define EQSPI_DRV_WMASK       8'hfe
`define EQSPI_CABLE_MAX       8'hf7
`endif

// file: src/eqspi_pkg.sv
// Types shared by the equalizer control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package eqspi_pkg;
  typedef enum logic [1:0] {
    EQSPI_SLEEP_NEVER  = 2'b00,
    EQSPI_SLEEP_AUTO   = 2'b01,
    EQSPI_SLEEP_FORCE  = 2'b10,
    EQSPI_SLEEP_RSVD   = 2'b11
  } eqspi_sleep_t;
  typedef enum logic [1:0] {
    EQSPI_OUT_NORMAL = 2'b00,
    EQSPI_OUT_BYPASS = 2'b01,
    EQSPI_OUT_MUTED  = 2'b10,
    EQSPI_OUT_ASLEEP = 2'b11
  } eqspi_out_t;
endpackage

// file: src/eqspi_link.sv
// Serial side of the bank: 16-bit pass-through shift path on the serial clock.
// Assumes sclk only toggles while sel_n is low; mode 0 sampling on rising edge.
`include "eqspi_cfg.svh"
module eqspi_link #(
  parameter int FRAME_BITS = `EQSPI_FRAME_BITS
) (
  // Serial pins
  input  wire logic                  sclk,
  input  wire logic                  sel_n,
  input  wire logic                  sdi,
  output logic                       sdo,
  // Frame view toward the core
  input  wire logic [FRAME_BITS-1:0] load_word,
  output logic [FRAME_BITS-1:0]      shift_word,
  output logic                       load_toggle
);
  // Refuse a frame width that the flag, address and data split cannot serve
  if (FRAME_BITS != 16) begin : g_frame_check
    $error("eqspi_link: frame must be 16 bits");
  end

  logic [FRAME_BITS-1:0] shreg;
  logic                  first_reg;
  logic                  sdo_reg;

  // Marks the first edge of a frame so the core's answer word is reloaded
  always_ff @(posedge sclk or posedge sel_n) begin
    if (sel_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  // Shift path: previous word leaves as the new one enters
  always_ff @(posedge sclk) begin
    if (first_reg) begin
      shreg <= {load_word[FRAME_BITS-2:0], sdi};
    end else begin
      shreg <= {shreg[FRAME_BITS-2:0], sdi};
    end
  end

  // Later bits change on the falling edge, half a bit ahead of the next sample
  always_ff @(negedge sclk or posedge sel_n) begin
    if (sel_n) begin
      sdo_reg <= 1'b0;
    end else begin
      sdo_reg <= shreg[FRAME_BITS-1];
    end
  end

  // First bit has no edge ahead of its sample, so it comes from the answer word
  assign sdo = first_reg ? load_word[FRAME_BITS-1] : sdo_reg;

  // Frame end is seen by the core via sel_n; word is stable while sel_n high
  assign shift_word  = shreg;
  assign load_toggle = first_reg;
endmodule

// file: src/eqspi_regs.sv
// Control and status bank of the cable equalizer, reached over a daisy-chained serial port.
// Assumes clk at 40 MHz, srst synchronous; sclk and sel_n come from the chain host.
`include "eqspi_cfg.svh"
module eqspi_regs (
  // System
  input  wire logic       clk,
  input  wire logic       srst,
  // Serial link, own clock domain
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // Analog core status
  input  wire logic       carrier_det,
  input  wire logic [7:0] cable_length_value,
  // Analog core controls
  output logic [1:0]      swing_sel,
  output logic [1:0]      vcm_sel,
  output logic            deemph_en,
  output logic [1:0]      deemph_level,
  output logic            launch_atten,
  output logic            out_mute,
  output logic            eq_bypass,
  output logic            eq_sleep
);
  logic [15:0] shift_word;
  logic        frame_first;
  logic [15:0] answer_reg;
  logic [7:0]  gen_reg;
  logic [7:0]  drv_reg;
  logic [7:0]  lau_reg;
  logic [2:0]  sel_sync;
  logic [2:0]  car_sync;
  logic        sel_high_reg;
  logic        car_reg;
  logic [7:0]  cable_reg;
  logic [7:0]  rd_next;
  logic        wr_strobe;
  logic        dummy_read;
  logic        sleep_next;
  eqspi_pkg::eqspi_sleep_t sleep_pol;

  // Shift path on the link clock
  eqspi_link #(
    .FRAME_BITS (`EQSPI_FRAME_BITS)
  ) u_link (
    .sclk        (sclk),
    .sel_n       (sel_n),
    .sdi         (sdi),
    .sdo         (sdo),
    .load_word   (answer_reg),
    .shift_word  (shift_word),
    .load_toggle (frame_first)
  );

  // Output enable straight from select level; tristate while deselected
  assign sdo_oe = ~sel_n;

  // Three-stage sync of select; change counts when stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_sync     <= 3'h7;
      sel_high_reg <= 1'b1;
    end else begin
      sel_sync <= {sel_sync[1:0], sel_n};
      if (sel_sync[1] == sel_sync[2]) begin
        sel_high_reg <= sel_sync[2];
      end
    end
  end

  // Frame ends on the filtered rising edge of select
  assign wr_strobe = (sel_sync[1] == sel_sync[2]) && sel_sync[2] && !sel_high_reg;

  // All-ones address is the chain's dummy read; the word passes untouched for length probes
  assign dummy_read = shift_word[15] && (shift_word[14:8] == `EQSPI_ADDR_DUMMY);

  // Carrier detect sync, same filter as select
  always_ff @(posedge clk) begin
    if (srst) begin
      car_sync <= 3'h0;
      car_reg  <= 1'b0;
    end else begin
      car_sync <= {car_sync[1:0], carrier_det};
      if (car_sync[1] == car_sync[2]) begin
        car_reg <= car_sync[2];
      end
    end
  end

  // Cable reading sampled each cycle between frames; follows the loop, so may wander
  always_ff @(posedge clk) begin
    if (srst) begin
      cable_reg <= 8'h00;
    end else if (sel_high_reg) begin
      // Only refreshed between frames so a read latch sees a settled byte
      cable_reg <= (cable_length_value > `EQSPI_CABLE_MAX) ? `EQSPI_CABLE_MAX
                                                           : cable_length_value;
    end
  end
  // Scale (1.25 m to 191, 3.75 m above) is the reader's conversion; code passes raw counts

  // Read mux over the four implemented registers
  always_comb begin
    case (shift_word[14:8])
      `EQSPI_ADDR_GENERAL: rd_next = {car_reg, gen_reg[6:0]};
      `EQSPI_ADDR_DRIVER:  rd_next = drv_reg;
      `EQSPI_ADDR_LAUNCH:  rd_next = lau_reg;
      `EQSPI_ADDR_CABLE:   rd_next = cable_reg;
      default:             rd_next = 8'h00;
    endcase
  end

  // Answer word: the frame just shifted, low byte replaced on a read other than the dummy read
  // shift_word is quiet while select is high, so it is safe to sample here
  always_ff @(posedge clk) begin
    if (srst) begin
      answer_reg <= 16'h0000;
    end else if (wr_strobe) begin
      answer_reg <= (shift_word[15] && !dummy_read) ? {shift_word[15:8], rd_next}
                                                    : shift_word;
    end
  end

  // General control: write flag 0, address, data
  always_ff @(posedge clk) begin
    if (srst) begin
      gen_reg <= `EQSPI_RST_GENERAL;
    end else if (wr_strobe && !shift_word[15]
                 && shift_word[14:8] == `EQSPI_ADDR_GENERAL) begin
      gen_reg <= shift_word[7:0] & `EQSPI_GEN_WMASK;
    end
  end

  // Output driver: reserved bit 0 reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      drv_reg <= `EQSPI_RST_DRIVER;
    end else if (wr_strobe && !shift_word[15]
                 && shift_word[14:8] == `EQSPI_ADDR_DRIVER) begin
      drv_reg <= shift_word[7:0] & `EQSPI_DRV_WMASK;
    end
  end

  // Launch amplitude
  always_ff @(posedge clk) begin
    if (srst) begin
      lau_reg <= `EQSPI_RST_LAUNCH;
    end else if (wr_strobe && !shift_word[15]
                 && shift_word[14:8] == `EQSPI_ADDR_LAUNCH) begin
      lau_reg <= shift_word[7:0];
    end
  end

  // Sleep policy decode; reserved code treated as never-sleep
  assign sleep_pol = eqspi_pkg::eqspi_sleep_t'(gen_reg[`EQSPI_GEN_SLEEP_HI:`EQSPI_GEN_SLEEP_LO]);
  always_comb begin
    case (sleep_pol)
      eqspi_pkg::EQSPI_SLEEP_AUTO:  sleep_next = !car_reg;
      eqspi_pkg::EQSPI_SLEEP_FORCE: sleep_next = 1'b1;
      default:                      sleep_next = 1'b0;
    endcase
  end

  // Analog controls with precedence sleep > mute > bypass
  always_ff @(posedge clk) begin
    if (srst) begin
      eq_sleep  <= 1'b0;
      out_mute  <= 1'b0;
      eq_bypass <= 1'b0;
    end else begin
      eq_sleep  <= sleep_next;
      out_mute  <= !sleep_next && gen_reg[`EQSPI_GEN_MUTE];
      eq_bypass <= !sleep_next && !gen_reg[`EQSPI_GEN_MUTE]
                   && gen_reg[`EQSPI_GEN_BYPASS];
    end
  end

  // Driver and launch fields to the analog core
  always_ff @(posedge clk) begin
    if (srst) begin
      swing_sel    <= 2'h2;
      vcm_sel      <= 2'h2;
      deemph_en    <= 1'b0;
      deemph_level <= 2'h1;
      launch_atten <= 1'b0;
    end else begin
      swing_sel    <= drv_reg[`EQSPI_DRV_SWING_HI:`EQSPI_DRV_SWING_LO];
      vcm_sel      <= drv_reg[`EQSPI_DRV_VCM_HI:`EQSPI_DRV_VCM_LO];
      deemph_en    <= drv_reg[`EQSPI_DRV_DEEMPH_EN];
      deemph_level <= drv_reg[`EQSPI_DRV_DEEMPH_HI:`EQSPI_DRV_DEEMPH_LO];
      launch_atten <= lau_reg[`EQSPI_LAU_ATTEN];
    end
  end

  // Sleep precedence
  property p_sleep_wins;
    @(posedge clk) disable iff (srst) eq_sleep |-> !out_mute && !eq_bypass;
  endproperty
  a_sleep_wins: assert property (p_sleep_wins) else $error("sleep with mute or bypass");

  // Mute beats bypass
  property p_mute_wins;
    @(posedge clk) disable iff (srst) out_mute |-> !eq_bypass;
  endproperty
  a_mute_wins: assert property (p_mute_wins) else $error("mute with bypass");

  // Forced sleep
  property p_force_sleep;
    @(posedge clk) disable iff (srst)
      (gen_reg[4:3] == 2'b10) |=> eq_sleep;
  endproperty
  a_force_sleep: assert property (p_force_sleep) else $error("forced sleep missing");

  // Write lands one cycle after frame end
  sequence s_drv_write;
    wr_strobe && !shift_word[15] && shift_word[14:8] == 7'h01;
  endsequence
  property p_drv_write;
    @(posedge clk) disable iff (srst)
      s_drv_write |=> drv_reg == (shift_word[7:0] & 8'hfe) ##1 swing_sel == shift_word[7:6];
  endproperty
  a_drv_write: assert property (p_drv_write) else $error("driver write lost");

  // No write to the general or launch register without frame end
  property p_no_stray_write;
    @(posedge clk) disable iff (srst) !wr_strobe |=> $stable(gen_reg) && $stable(lau_reg);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("stray write");

  // Read answer loads register data
  property p_read_answer;
    @(posedge clk) disable iff (srst)
      (wr_strobe && shift_word[15] && shift_word[14:8] == 7'h02)
        |=> answer_reg[7:0] == lau_reg;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

  // Reading stays in range
  property p_cable_range;
    @(posedge clk) disable iff (srst) cable_reg <= 8'hf7;
  endproperty
  a_cable_range: assert property (p_cable_range) else $error("cable reading out of range");

  // Auto sleep follows carrier
  property p_auto_sleep;
    @(posedge clk) disable iff (srst)
      (gen_reg[4:3] == 2'b01 && !car_reg) |=> eq_sleep;
  endproperty
  a_auto_sleep: assert property (p_auto_sleep) else $error("auto sleep missing");

  // Write pass-through
  property p_pass;
    @(posedge clk) disable iff (srst)
      (wr_strobe && !shift_word[15]) |=> answer_reg == $past(shift_word);
  endproperty
  a_pass: assert property (p_pass) else $error("word not passed on");

  // Dummy read passes the probe word on unchanged
  property p_dummy_pass;
    @(posedge clk) disable iff (srst) (wr_strobe && dummy_read) |=> answer_reg == shift_word;
  endproperty
  a_dummy_pass: assert property (p_dummy_pass) else $error("dummy word altered");

  // General read carries the carrier flag beside the stored bits
  property p_gen_read;
    @(posedge clk) disable iff (srst)
      (wr_strobe && shift_word[15] && shift_word[14:8] == 7'h00)
        |=> answer_reg[7:0] == {$past(car_reg), gen_reg[6:0]};
  endproperty
  a_gen_read: assert property (p_gen_read) else $error("general read wrong");

  // Cable read returns the reading frozen at frame end
  property p_cable_read;
    @(posedge clk) disable iff (srst)
      (wr_strobe && shift_word[15] && shift_word[14:8] == 7'h06)
        |=> answer_reg[7:0] == $past(cable_reg);
  endproperty
  a_cable_read: assert property (p_cable_read) else $error("cable read wrong");

  // One commit per select rise
  property p_single_strobe;
    @(posedge clk) disable iff (srst) wr_strobe |=> !wr_strobe;
  endproperty
  a_single_strobe: assert property (p_single_strobe) else $error("double commit");

  // Never-sleep and reserved codes keep the equalizer awake
  property p_never_sleep;
    @(posedge clk) disable iff (srst) (gen_reg[4] == gen_reg[3]) |=> !eq_sleep;
  endproperty
  a_never_sleep: assert property (p_never_sleep) else $error("sleep without cause");

  // Auto policy stays awake while a carrier is present
  property p_carrier_wake;
    @(posedge clk) disable iff (srst)
      (gen_reg[4:3] == 2'b01 && car_reg) |=> !eq_sleep;
  endproperty
  a_carrier_wake: assert property (p_carrier_wake) else $error("slept with carrier");

  // Mute reaches the output when awake, whatever bypass says
  property p_mute_set;
    @(posedge clk) disable iff (srst)
      (gen_reg[4:3] == 2'b00 && gen_reg[6]) |=> out_mute;
  endproperty
  a_mute_set: assert property (p_mute_set) else $error("mute missing");

  // Bypass reaches the output when awake and unmuted
  property p_bypass_set;
    @(posedge clk) disable iff (srst)
      (gen_reg[4:3] == 2'b00 && gen_reg[6:5] == 2'b01) |=> eq_bypass;
  endproperty
  a_bypass_set: assert property (p_bypass_set) else $error("bypass missing");

  // Driver fields follow the register one cycle later; bit 0 stays clear
  property p_drv_fields;
    @(posedge clk) disable iff (srst)
      1'b1 |=> {swing_sel, vcm_sel, deemph_en, deemph_level, 1'b0} == $past(drv_reg);
  endproperty
  a_drv_fields: assert property (p_drv_fields) else $error("driver fields wrong");

  // Launch setting follows its register bit one cycle later
  property p_launch_field;
    @(posedge clk) disable iff (srst)
      1'b1 |=> {launch_atten, 7'h00} == ($past(lau_reg) & 8'h80);
  endproperty
  a_launch_field: assert property (p_launch_field) else $error("launch setting wrong");

  // Reading frozen while a frame is under way
  property p_cable_hold;
    @(posedge clk) disable iff (srst) !sel_high_reg |=> $stable(cable_reg);
  endproperty
  a_cable_hold: assert property (p_cable_hold) else $error("reading moved mid-frame");

  // First serial edge loads the answer word behind the incoming bit
  property p_first_load;
    @(posedge sclk) disable iff (sel_n) frame_first |=> shift_word[15:1] == answer_reg[14:0];
  endproperty
  a_first_load: assert property (p_first_load) else $error("answer word not loaded");
endmodule

// file: verif/eqspi_host.sv
// Host model for the serial chain: sends 16-bit frames, MSB first, mode 0.
// Assumes one device in the chain; its serial clock runs only inside a frame.
module eqspi_host (
  // Serial pins
  output logic      sclk,
  output logic      sel_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic miso_last;

  // Idle pins at start
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
    miso_last = 1'b0;
  end

  // One frame; an undriven return line is read as the inverse of its last bit
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    sel_n = 1'b0;
    #3;
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      #3 sclk = 1'b1;
      miso_last = sdo_oe ? sdo : ~miso_last;
      rx[i] = miso_last;
      #3 sclk = 1'b0;
    end
    #3 sel_n = 1'b1;
    sdi = ~sdi; // Released line must not look stable
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the equalizer control bank.
// Assumes eqspi_host drives the serial side; the bench drives clk-domain inputs.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, carrier_det, sclk, sel_n, sdi, sdo, sdo_oe;
  logic [7:0]  cable_length_value, drv_s, lau_s, gen_s, cab[8];
  logic [1:0]  swing_sel, vcm_sel, deemph_level, c;
  logic        deemph_en, launch_atten, out_mute, eq_bypass, eq_sleep;
  logic [10:0] outs;
  logic [15:0] rx;
  int          miscompares, n_checks, k;

  eqspi_regs eqspi_regs_i (.clk(clk), .srst(srst), .sclk(sclk), .sel_n(sel_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .carrier_det(carrier_det),
    .cable_length_value(cable_length_value), .swing_sel(swing_sel),
    .vcm_sel(vcm_sel), .deemph_en(deemph_en), .deemph_level(deemph_level),
    .launch_atten(launch_atten), .out_mute(out_mute), .eq_bypass(eq_bypass),
    .eq_sleep(eq_sleep));
  eqspi_host eqspi_host_i (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));

  // All analog controls as one vector
  assign outs = {swing_sel, vcm_sel, deemph_en, deemph_level, launch_atten,
                 out_mute, eq_bypass, eq_sleep};

  // System clock, 25 ns
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Expected controls: sleep beats mute, mute beats bypass
  function automatic logic [10:0] exp_outs(logic [7:0] dv, logic [7:0] la,
                                           logic [7:0] g, logic car);
    logic sl;
    sl = (g[4:3] == 2'b10) || (g[4:3] == 2'b01 && !car);
    return {dv[7:1], la[7], sl ? 1'b0 : g[6], (sl || g[6]) ? 1'b0 : g[5], sl};
  endfunction

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // Gap after each frame covers commit latency and minimum idle time
  task automatic gap();
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [6:0] a, logic [7:0] v);
    eqspi_host_i.xfer({1'b0, a, v}, rx);
    gap();
  endtask

  // Read request, then a dummy frame that carries the answer
  task automatic rdchk(string nm, logic [6:0] a, logic [7:0] v);
    eqspi_host_i.xfer({1'b1, a, 8'hff}, rx);
    gap();
    eqspi_host_i.xfer(16'hffff, rx);
    chk("rd_hdr", {8'h01, 1'b1, a}, {8'h01, rx[15:8]});
    chk(nm, 16'(v), 16'(rx[7:0]));
    gap();
  endtask

  // Output enable must hold through every frame
  always @(posedge sclk) chk("sdo_oe", 16'h1, 16'(sdo_oe));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #1000000;
    miscompares++;
    close_out();
  end

  initial begin
    srst = 1'b1;
    carrier_det = 1'b1;
    cable_length_value = 8'h00;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'h4c7c5194));
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    gap();
    drv_s = 8'ha2;
    lau_s = 8'h68;
    gen_s = 8'h08;
    chk("sdo_oe_idle", 16'h0, 16'(sdo_oe));
    chk("outs_rst", 16'(exp_outs(drv_s, lau_s, gen_s, 1'b1)), 16'(outs));
    rdchk("gen_rst", 7'h00, 8'h88);
    rdchk("drv_rst", 7'h01, 8'ha2);
    rdchk("lau_rst", 7'h02, 8'h68);
    $display("test reset done");
    // Count dummy words until the marker byte comes back
    k = 0;
    do begin
      eqspi_host_i.xfer(16'hff5a, rx);
      gap();
      k++;
    end while (rx !== 16'hff5a && k < 6);
    chk("chain_words", 16'h2, 16'(k));
    $display("test chain done");
    // Every swing, common-mode and level code, then random settings
    for (int i = 0; i < 12; i++) begin
      c = i[1:0];
      drv_s = (i < 4) ? {c, c, c[0], c, 1'b1} : 8'($urandom);
      lau_s = {1'($urandom), 7'h68};
      wr(7'h01, drv_s);
      wr(7'h02, lau_s);
      chk("outs_drv", 16'(exp_outs(drv_s, lau_s, gen_s, 1'b1)), 16'(outs));
      rdchk("drv_rd", 7'h01, drv_s & 8'hfe);
      rdchk("lau_rd", 7'h02, lau_s);
    end
    $display("test driver done");
    // All mute, bypass and sleep codes, with and without carrier
    for (int i = 0; i < 32; i++) begin
      carrier_det = i[4];
      gen_s = {1'b1, i[1:0], i[3:2], 3'b000};
      wr(7'h00, gen_s);
      chk("outs_gen", 16'(exp_outs(drv_s, lau_s, gen_s, i[4])), 16'(outs));
      rdchk("gen_rd", 7'h00, {i[4], gen_s[6:0]});
    end
    $display("test general done");
    // Cable reading at its range edges, the 191 break, the all-ones input, then random
    cab = '{8'h00, 8'hbf, 8'hc0, 8'hf7, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int j = 5; j < 8; j++) cab[j] = 8'($urandom_range(0, 247));
    foreach (cab[j]) begin
      cable_length_value = cab[j];
      gap();
      rdchk("cable", 7'h06, (cab[j] > 8'hf7) ? 8'hf7 : cab[j]);
    end
    $display("test cable done");
    wr(7'h03, 8'h5a);
    rdchk("unmapped", 7'h03, 8'h00);
    chk("outs_unmapped", 16'(exp_outs(drv_s, lau_s, gen_s, 1'b1)), 16'(outs));
    $display("test unmapped done");
    close_out();
  end
endmodule
